/* csseq_defines.svh */
// constant definitions for the clock generator startup sequencer
`ifndef CSSEQ_DEFINES_SVH
`define CSSEQ_DEFINES_SVH
// ==========================================================
// register byte addresses
`define CSSEQ_ADDR_CTRL    12'h000
`define CSSEQ_ADDR_STATUS  12'h004
`define CSSEQ_ADDR_PINCFG  12'h008
`define CSSEQ_ADDR_PSDIV   12'h00C
`define CSSEQ_ADDR_CHDIV0  12'h010
// ==========================================================
// field positions and values
`define CSSEQ_CTRL_RESTART 0
`define CSSEQ_CTRL_MUTEREL 1
`define CSSEQ_PS_MAX       2'h2
`define CSSEQ_PS_BASE      5'h04
`define CSSEQ_DIV_MIN      14'h0001
`define CSSEQ_RST_PINCFG   10'h000
`define CSSEQ_RST_CHDIV    14'h0001
`define CSSEQ_PAGE_WORDS   4'h8
`define CSSEQ_SYNC_CYCLES  4'h4
`endif

/* csseq_pkg.sv */
// types shared by the clock generator startup sequencer
`default_nettype none
package csseq_pkg;
  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    CSSEQ_IDLE  = 7'h01,
    CSSEQ_LOAD  = 7'h02,
    CSSEQ_APPLY = 7'h04,
    CSSEQ_CAL   = 7'h08,
    CSSEQ_LOCK  = 7'h10,
    CSSEQ_SYNC  = 7'h20,
    CSSEQ_RUN   = 7'h40
  } csseq_state_e;

  // page memory read port
  typedef struct packed {
    logic        req;
    logic        page;
    logic [2:0]  addr;
  } csseq_nvm_req_s;

  // block outputs toward the analog blocks
  typedef struct packed {
    logic        cal_start;
    logic        outputs_muted;
    logic        div_sync;
    logic        div_release;
  } csseq_ctl_s;

  // whole state of the sequencer
  typedef struct packed {
    csseq_state_e       st;
    logic [3:0]         widx;
    logic               page;
    logic [9:0]         pincfg;
    logic               mode_serial;
    logic [1:0]         ps_code;
    logic [13:0]        ref_div;
    logic [55:0]        chdiv;
    logic [3:0]         cnt;
    logic               mute_release;
    logic               restart;
    logic [31:0]        prdata;
    logic               pslverr;
    csseq_ctl_s         ctl;
  } csseq_state_s;
endpackage
`default_nettype wire

/* csseq_top.sv */
// startup sequencer: page load, calibration, lock wait, divider sync
//Behaviour
//- stay idle until the power-on-release event has fired
//- copy the selected page to working registers, then apply them
//- page-select pin low loads page 0, high loads page 1
//- keep differential outputs muted through calibration and lock
//- after lock, synchronize all output dividers, then release them
//- first pin is the reset input unless loaded config says otherwise
//- reset input low blocks leaving idle and holds the serial interface in reset
//- with no reset pin assigned, start only from power-on release
//- all five pin functions and directions come from the loaded page
//- loaded page selects pin mode or serial-interface mode
//- channel dividers accept 1 through 16383
//- prescaler code 0 to 2, factor is code plus 4
`timescale 1ns/1ps
`default_nettype none
`include "csseq_defines.svh"
module csseq_top #(
  parameter int NCH = 4
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        por_release,
  input  wire logic        config_page_select,
  input  wire logic        pin0_in,
  output logic             pin0_out,
  output logic             pin0_oe_n,
  input  wire logic        pll_locked,
  input  wire logic        cal_done,
  output csseq_pkg::csseq_nvm_req_s nvm_req,
  input  wire logic [15:0] nvm_rdata,
  input  wire logic        nvm_valid,
  output csseq_pkg::csseq_ctl_s ctl,
  output logic [9:0]       pin_function_config_a,
  output logic             serial_mode,
  output logic             serial_hold,
  output logic [1:0]       vco_prescaler_code,
  output logic [13:0]      reference_predivider,
  output logic [55:0]      channel_output_divider,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] por_s, sel_s, hold_s, lock_s;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // every async input passes two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_s  <= 2'h0;
      sel_s  <= 2'h0;
      hold_s <= 2'h0;
      lock_s <= 2'h0;
    end else begin
      por_s  <= {por_s[0], por_release};
      sel_s  <= {sel_s[0], config_page_select};
      hold_s <= {hold_s[0], pin0_in};
      lock_s <= {lock_s[0], pll_locked};
    end
  end

  // ==========================================================
  // helpers
  // clamp a divider into the legal range 1..16383
  function automatic logic [13:0] clamp_div(input logic [13:0] v);
    clamp_div = (v < `CSSEQ_DIV_MIN) ? `CSSEQ_DIV_MIN : v;
  endfunction
  // clamp prescaler code to 0..2
  function automatic logic [1:0] clamp_ps(input logic [1:0] v);
    clamp_ps = (v > `CSSEQ_PS_MAX) ? `CSSEQ_PS_MAX : v;
  endfunction

  csseq_pkg::csseq_state_s r, next_r;
  logic reset_pin_active;
  logic hold_active;
  logic apb_wr, apb_rd, apb_setup;

  // first pin is the reset input while its config bits are zero
  assign reset_pin_active = (r.pincfg[1:0] == 2'h0);
  assign hold_active = reset_pin_active && !hold_s[1];
  assign apb_wr = psel && penable && pwrite;
  // reads and errors are decoded in setup so the answer stands in access
  assign apb_rd = psel && !penable && !pwrite;
  assign apb_setup = psel && !penable;

  // ==========================================================
  // sequencer and register file
  always_comb begin
    next_r = r;
    next_r.ctl.cal_start = 1'b0;
    next_r.ctl.div_sync  = 1'b0;
    next_r.restart       = 1'b0;
    case (r.st)
      csseq_pkg::CSSEQ_IDLE: begin
        next_r.ctl.outputs_muted = 1'b1;
        next_r.ctl.div_release   = 1'b0;
        if (por_s[1] && !hold_active) begin
          next_r.page = sel_s[1];
          next_r.widx = 4'h0;
          next_r.st   = csseq_pkg::CSSEQ_LOAD;
        end
      end
      csseq_pkg::CSSEQ_LOAD: begin
        if (nvm_valid) begin
          case (r.widx[2:0])
            3'h0: begin
              next_r.pincfg      = nvm_rdata[9:0];
              next_r.mode_serial = nvm_rdata[15];
            end
            3'h1: next_r.ps_code = clamp_ps(nvm_rdata[1:0]);
            3'h2: next_r.ref_div = clamp_div(nvm_rdata[13:0]);
            3'h3: next_r.chdiv[13:0]  = clamp_div(nvm_rdata[13:0]);
            3'h4: next_r.chdiv[27:14] = clamp_div(nvm_rdata[13:0]);
            3'h5: next_r.chdiv[41:28] = clamp_div(nvm_rdata[13:0]);
            3'h6: next_r.chdiv[55:42] = clamp_div(nvm_rdata[13:0]);
            default: ;
          endcase
          next_r.widx = r.widx + 4'h1;
          if (r.widx == `CSSEQ_PAGE_WORDS - 4'h1) begin
            next_r.st = csseq_pkg::CSSEQ_APPLY;
          end
        end
      end
      csseq_pkg::CSSEQ_APPLY: begin
        // settings now drive the outputs; calibrate only afterwards
        next_r.ctl.cal_start = 1'b1;
        next_r.st = csseq_pkg::CSSEQ_CAL;
      end
      csseq_pkg::CSSEQ_CAL: begin
        if (cal_done) begin
          next_r.st = csseq_pkg::CSSEQ_LOCK;
        end
      end
      csseq_pkg::CSSEQ_LOCK: begin
        if (lock_s[1]) begin
          next_r.cnt = 4'h0;
          next_r.st  = csseq_pkg::CSSEQ_SYNC;
        end
      end
      csseq_pkg::CSSEQ_SYNC: begin
        // hold sync for a few cycles so every divider sees it
        next_r.ctl.div_sync = 1'b1;
        next_r.cnt = r.cnt + 4'h1;
        // compare against the full count so sync stands exactly that many cycles
        if (r.cnt == `CSSEQ_SYNC_CYCLES) begin
          next_r.ctl.div_sync    = 1'b0;
          next_r.ctl.div_release = 1'b1;
          next_r.st = csseq_pkg::CSSEQ_RUN;
        end
      end
      csseq_pkg::CSSEQ_RUN: begin
        next_r.ctl.outputs_muted = !r.mute_release;
        if (!lock_s[1] || r.restart) begin
          next_r.st = csseq_pkg::CSSEQ_IDLE;
        end
      end
      default: next_r.st = csseq_pkg::CSSEQ_IDLE;
    endcase
    // outputs stay muted until run state
    if (r.st != csseq_pkg::CSSEQ_RUN) begin
      next_r.ctl.outputs_muted = 1'b1;
    end
    // apb slave, zero wait states; a write lands at the access edge
    next_r.pslverr = 1'b0;
    if (apb_wr && paddr == `CSSEQ_ADDR_CTRL) begin
      next_r.restart      = pwdata[`CSSEQ_CTRL_RESTART];
      next_r.mute_release = pwdata[`CSSEQ_CTRL_MUTEREL];
    end
    // error flag is decided in setup, so it already stands when pready is seen
    if (apb_setup && pwrite) begin
      case (paddr)
        `CSSEQ_ADDR_CTRL, `CSSEQ_ADDR_STATUS, `CSSEQ_ADDR_PINCFG, `CSSEQ_ADDR_PSDIV: ;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        `CSSEQ_ADDR_CTRL:   next_r.prdata = {30'h0, r.mute_release, 1'b0};
        `CSSEQ_ADDR_STATUS: next_r.prdata = {21'h0, r.page, r.mode_serial,
                                             hold_active, 1'b0, 7'(r.st)};
        `CSSEQ_ADDR_PINCFG: next_r.prdata = {22'h0, r.pincfg};
        `CSSEQ_ADDR_PSDIV:  next_r.prdata = {2'h0, r.ref_div, 14'h0, r.ps_code};
        `CSSEQ_ADDR_CHDIV0: next_r.prdata = {18'h0, r.chdiv[13:0]};
        default: begin
          next_r.prdata  = 32'h0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  // state register, reset to its start values while rst_n is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: csseq_pkg::CSSEQ_IDLE, widx: 4'h0, page: 1'b0,
             pincfg: `CSSEQ_RST_PINCFG, mode_serial: 1'b0, ps_code: 2'h0,
             ref_div: `CSSEQ_RST_CHDIV, chdiv: {4{`CSSEQ_RST_CHDIV}}, cnt: 4'h0,
             mute_release: 1'b1, restart: 1'b0, prdata: 32'h0, pslverr: 1'b0,
             ctl: '{cal_start: 1'b0, outputs_muted: 1'b1, div_sync: 1'b0,
                    div_release: 1'b0}};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // output assignments
  assign nvm_req.req  = (r.st == csseq_pkg::CSSEQ_LOAD);
  assign nvm_req.page = r.page;
  assign nvm_req.addr = r.widx[2:0];
  assign ctl          = r.ctl;
  assign pin_function_config_a  = r.pincfg;
  assign serial_mode            = r.mode_serial;
  assign serial_hold            = hold_active;
  assign vco_prescaler_code     = r.ps_code;
  assign reference_predivider   = r.ref_div;
  assign channel_output_divider = r.chdiv;
  // pin 0 drives a status (run) when configured as output
  assign pin0_oe_n = !(r.pincfg[1:0] == 2'h1);
  assign pin0_out  = (r.st == csseq_pkg::CSSEQ_RUN);
  assign prdata  = r.prdata;
  assign pslverr = r.pslverr;
  assign pready  = 1'b1;

  // ==========================================================
  // assertions
  property p_idle_before_por;
    @(posedge core_clk) disable iff (!rst_n)
      !por_s[1] |-> ##1 (r.st == csseq_pkg::CSSEQ_IDLE);
  endproperty
  a_idle_before_por: assert property (p_idle_before_por)
    else $error("left idle before power-on release");

  property p_page_pick;
    @(posedge core_clk) disable iff (!rst_n)
      (r.st == csseq_pkg::CSSEQ_IDLE && por_s[1] && !hold_active)
        |=> (r.page == $past(sel_s[1]));
  endproperty
  a_page_pick: assert property (p_page_pick)
    else $error("wrong page selected");

  property p_muted_early;
    @(posedge core_clk) disable iff (!rst_n)
      (r.st == csseq_pkg::CSSEQ_CAL || r.st == csseq_pkg::CSSEQ_LOCK)
        |-> r.ctl.outputs_muted;
  endproperty
  a_muted_early: assert property (p_muted_early)
    else $error("outputs unmuted during calibration");

  property p_sync_then_release;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(r.ctl.div_sync) |-> r.ctl.div_sync [*4] ##1 r.ctl.div_release;
  endproperty
  a_sync_then_release: assert property (p_sync_then_release)
    else $error("divider release not after sync");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (hold_active && r.st == csseq_pkg::CSSEQ_IDLE)
        |=> r.st == csseq_pkg::CSSEQ_IDLE;
  endproperty
  a_hold: assert property (p_hold)
    else $error("startup not held by reset input");

  property p_div_range;
    @(posedge core_clk) disable iff (!rst_n)
      r.chdiv[13:0] >= `CSSEQ_DIV_MIN && r.chdiv[55:42] >= `CSSEQ_DIV_MIN;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("channel divider out of range");

  property p_ps_range;
    @(posedge core_clk) disable iff (!rst_n) r.ps_code <= `CSSEQ_PS_MAX;
  endproperty
  a_ps_range: assert property (p_ps_range)
    else $error("prescaler code out of range");

  property p_load_first;
    @(posedge core_clk) disable iff (!rst_n)
      r.ctl.cal_start |-> ($past(r.st) == csseq_pkg::CSSEQ_APPLY) ##1
        (r.st == csseq_pkg::CSSEQ_CAL || r.st == csseq_pkg::CSSEQ_LOCK);
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("calibration before page loaded");

  // divider release only ever follows a sync burst
  property p_release_after_sync;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(r.ctl.div_release) |-> $past(r.ctl.div_sync);
  endproperty
  a_release_after_sync: assert property (p_release_after_sync)
    else $error("divider release without sync");

  // with the pin function moved elsewhere only power-on release gates the start
  property p_start_no_pin;
    @(posedge core_clk) disable iff (!rst_n)
      (r.st == csseq_pkg::CSSEQ_IDLE && por_s[1] && !reset_pin_active)
        |=> r.st == csseq_pkg::CSSEQ_LOAD;
  endproperty
  a_start_no_pin: assert property (p_start_no_pin)
    else $error("start blocked without reset pin");

  // first page word carries the operating mode bit
  property p_mode_load;
    @(posedge core_clk) disable iff (!rst_n)
      (r.st == csseq_pkg::CSSEQ_LOAD && nvm_valid && r.widx == 4'h0)
        |=> serial_mode == $past(nvm_rdata[15]);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("operating mode not taken from page");

  // read data must already stand in the access cycle
  property p_read_answer;
    @(posedge core_clk) disable iff (!rst_n)
      (psel && penable && !pwrite && paddr == `CSSEQ_ADDR_PINCFG)
        |-> prdata == {22'h0, $past(pin_function_config_a)} && !pslverr;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("pin config read data not standing");

  c_load: cover property (@(posedge core_clk) r.st == csseq_pkg::CSSEQ_APPLY);
  c_page1: cover property (@(posedge core_clk) r.st == csseq_pkg::CSSEQ_LOAD && r.page);
  c_run: cover property (@(posedge core_clk) r.st == csseq_pkg::CSSEQ_RUN);
  c_sync: cover property (@(posedge core_clk) r.ctl.div_sync);
  c_bus_error: cover property (@(posedge core_clk) psel && penable && pslverr);
endmodule
`default_nettype wire

/* csseq_partner.sv */
// page memory, calibration and lock responder on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module csseq_partner (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      slow,
  input  wire csseq_pkg::csseq_nvm_req_s nvm_req,
  input  wire logic                      cal_start,
  output logic [15:0]                    nvm_rdata,
  output logic                           nvm_valid,
  output logic                           cal_done,
  output logic                           pll_locked
);
  // ==========================================================
  // two pages of eight words, page bit above the word address
  logic [15:0] mem [0:15];
  logic [4:0]  wcnt;
  logic [4:0]  ccnt;
  logic [4:0]  lcnt;
  logic [4:0]  lat;

  // slow mode stretches every answer to exercise the waits
  assign lat = slow ? 5'h09 : 5'h01;

  // word answers, calibration end and lock; idle data toggles so no stale word is seen
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wcnt       <= 5'h00;
      ccnt       <= 5'h00;
      lcnt       <= 5'h00;
      nvm_valid  <= 1'b0;
      nvm_rdata  <= 16'h0000;
      cal_done   <= 1'b0;
      pll_locked <= 1'b0;
    end else begin
      nvm_valid <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      cal_done  <= 1'b0;
      if (nvm_req.req && !nvm_valid) begin
        wcnt <= wcnt + 5'h01;
        if (wcnt == lat) begin
          wcnt      <= 5'h00;
          nvm_valid <= 1'b1;
          nvm_rdata <= mem[{nvm_req.page, nvm_req.addr}];
        end
      end
      // recalibration drops lock until the loop settles again
      if (cal_start) begin
        ccnt       <= lat;
        pll_locked <= 1'b0;
      end else if (ccnt != 5'h00) begin
        ccnt     <= ccnt - 5'h01;
        cal_done <= (ccnt == 5'h01);
      end
      if (cal_done) begin
        lcnt <= lat;
      end else if (lcnt != 5'h00) begin
        lcnt       <= lcnt - 5'h01;
        pll_locked <= (lcnt == 5'h01);
      end
    end
  end
endmodule
`default_nettype wire

/* test_clock_gen_startup_sequencer.sv */
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
`default_nettype none
`include "csseq_defines.svh"
module test_clock_gen_startup_sequencer;
  logic core_clk, nrst, por_release, config_page_select, pin0_in, slow;
  logic psel, penable, pwrite, pin0_out, pin0_oe_n, pll_locked, cal_done;
  logic nvm_valid, serial_mode, serial_hold, pready, pslverr, err, prev_sync;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] nvm_rdata;
  logic [9:0]  pin_function_config_a;
  logic [1:0]  vco_prescaler_code;
  logic [13:0] reference_predivider;
  logic [55:0] channel_output_divider, exp_div;
  csseq_pkg::csseq_nvm_req_s nvm_req;
  csseq_pkg::csseq_ctl_s     ctl;
  int fails, n_tests, sync_len;

  csseq_top dut (.core_clk(core_clk), .nrst(nrst), .por_release(por_release),
    .config_page_select(config_page_select), .pin0_in(pin0_in), .pin0_out(pin0_out),
    .pin0_oe_n(pin0_oe_n), .pll_locked(pll_locked), .cal_done(cal_done),
    .nvm_req(nvm_req), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .ctl(ctl),
    .pin_function_config_a(pin_function_config_a), .serial_mode(serial_mode),
    .serial_hold(serial_hold), .vco_prescaler_code(vco_prescaler_code),
    .reference_predivider(reference_predivider),
    .channel_output_divider(channel_output_divider), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  csseq_partner u_part (.core_clk(core_clk), .nrst(nrst), .slow(slow), .nvm_req(nvm_req),
    .cal_start(ctl.cal_start), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid),
    .cal_done(cal_done), .pll_locked(pll_locked));

  // ==========================================================
  // clock, reporting and bus tasks
  always #12.5 core_clk = ~core_clk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer; answer and read data are taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask

  // bounded wait for the divider release level
  task automatic wait_rel(input logic v);
    int i;
    i = 0;
    while (ctl.div_release !== v && i < 3000) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 3000) begin
      fails++;
      stop_test();
    end
  endtask

  // watch calibration start and the divider sync burst
  always @(posedge core_clk) begin
    if (ctl.cal_start === 1'b1) begin
      chk(64'(ctl.outputs_muted), 64'h1);
      chk(64'(channel_output_divider), 64'(exp_div));
    end
    if (ctl.div_sync === 1'b1 && prev_sync !== 1'b1) begin
      chk(64'(pll_locked), 64'h1);
      chk(64'({ctl.div_release, ctl.outputs_muted}), 64'h1);
    end
    if (ctl.div_sync !== 1'b1 && prev_sync === 1'b1) chk(64'(sync_len), 64'(`CSSEQ_SYNC_CYCLES));
    sync_len = (ctl.div_sync === 1'b1) ? sync_len + 1 : 0;
    prev_sync = ctl.div_sync;
  end

  // ==========================================================
  // main sequence
  initial begin
    {core_clk, nrst, por_release, config_page_select, slow, psel, penable, pwrite} = 8'h00;
    pin0_in = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    prev_sync = 1'b0;
    sync_len = 0;
    exp_div = {14'h0005, 14'h0002, 14'h3FFF, 14'h0001};
    u_part.mem = '{16'h0000, 16'h0001, 16'h0002, 16'h0001, 16'h3FFF, 16'h0002, 16'h0005,
      16'h0000, 16'h8001, 16'h0003, 16'h0123, 16'h0000, 16'h0007, 16'h3FFF, 16'h0010, 16'hFFFF};
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, `CSSEQ_ADDR_STATUS, 32'h0);
    chk(64'(d[6:0]), 64'(csseq_pkg::CSSEQ_IDLE));
    chk(64'(channel_output_divider), 64'({4{14'h0001}}));
    chk(64'(ctl.outputs_muted), 64'h1);
    $display("test idle before power-on release done");
    por_release <= 1'b1;
    repeat (20) @(posedge core_clk);
    apb(1'b0, `CSSEQ_ADDR_STATUS, 32'h0);
    chk(64'({d[8], d[6:0]}), 64'h81);
    chk(64'(serial_hold), 64'h1);
    pin0_in <= 1'b1;
    wait_rel(1'b1);
    apb(1'b0, `CSSEQ_ADDR_STATUS, 32'h0);
    chk(64'(d[10:0]), 64'h040);
    chk(64'({pin_function_config_a, serial_mode, vco_prescaler_code}), 64'h001);
    chk(64'(reference_predivider), 64'h2);
    chk(64'(channel_output_divider), 64'(exp_div));
    chk(64'({ctl.outputs_muted, pin0_oe_n}), 64'h1);
    $display("test page 0 startup done");
    config_page_select <= 1'b1;
    slow <= 1'b1;
    exp_div = {14'h0010, 14'h3FFF, 14'h0007, 14'h0001};
    apb(1'b1, `CSSEQ_ADDR_CTRL, 32'h0000_0003);
    wait_rel(1'b0);
    wait_rel(1'b1);
    apb(1'b0, `CSSEQ_ADDR_STATUS, 32'h0);
    chk(64'(d[10:0]), 64'h640);
    chk(64'({pin_function_config_a, serial_mode, vco_prescaler_code}), 64'h00E);
    chk(64'({pin0_oe_n, pin0_out}), 64'h1);
    chk(64'(channel_output_divider), 64'(exp_div));
    apb(1'b0, `CSSEQ_ADDR_PSDIV, 32'h0);
    chk(64'(d), 64'h0123_0002);
    $display("test page 1 startup done");
    pin0_in <= 1'b0;
    apb(1'b1, `CSSEQ_ADDR_CTRL, 32'h0000_0003);
    wait_rel(1'b0);
    wait_rel(1'b1);
    chk(64'(serial_hold), 64'h0);
    apb(1'b0, `CSSEQ_ADDR_STATUS, 32'h0);
    chk(64'(d[6:0]), 64'(csseq_pkg::CSSEQ_RUN));
    $display("test start without reset pin done");
    apb(1'b0, 12'hFFC, 32'h0);
    chk(64'(err), 64'h1);
    apb(1'b0, `CSSEQ_ADDR_PINCFG, 32'h0);
    chk(64'({err, d[9:0]}), 64'h001);
    $display("test register access done");
    stop_test();
  end
endmodule
`default_nettype wire
